// >>> include/bsse_pkg.sv
// package: constants for the branch, sleep and subtract-with-borrow executor
package bsse_pkg;
  // ****************************************
  // opcodes
  // ****************************************
  localparam logic [7:0] CARRY_CLEAR_HI = 8'he3; // 1110 0011
  localparam logic [7:0] NEG_CLEAR_HI = 8'he7; // 1110 0111
  localparam logic [15:0] SLEEP_CODE = 16'h0003;
  localparam logic [1:0] SUBB_TOP = 2'b01;
  localparam logic [3:0] SUBB_LOW = 4'h5;
  localparam logic [7:0] IDX_LIMIT = 8'h5f; // 95
  localparam logic [15:0] PC_STEP = 16'h0002;
  localparam logic [7:0] WATCHDOG_CLEAR = 8'h00;
  localparam logic [1:0] Q_RESET = 2'b00;
  // ****************************************
  // apb map
  // ****************************************
  localparam logic [7:0] A_INSTR = 8'h00; // write starts an instruction
  localparam logic [7:0] A_WORK = 8'h04;
  localparam logic [7:0] A_STATUS = 8'h08; // neg ovf zero digit carry
  localparam logic [7:0] A_BANK = 8'h0c;
  localparam logic [7:0] A_PC = 8'h10;
  localparam logic [7:0] A_CTRL = 8'h14; // bit0 ext set, bit1 timeout, bit2 powerdown, bit3 stop
  localparam logic [7:0] A_FSR2 = 8'h18;
  localparam logic [7:0] A_FILE = 8'h1c; // file reg data access, uses addr reg
  localparam logic [7:0] A_FADDR = 8'h20;
  localparam logic [7:0] A_WAKE = 8'h24; // write 1 = watchdog wake
  localparam logic [7:0] A_WATCHDOG = 8'h28;
  localparam logic [7:0] A_BUSY = 8'h2c;
  typedef enum logic [3:0] {
    BSSE_IDLE = 4'b0001,
    BSSE_RUN = 4'b0010,
    BSSE_NOP = 4'b0100,
    BSSE_SLEEP = 4'b1000
  } bsse_state_e;
endpackage : bsse_pkg

// >>> include/bsse_mem_if.sv
// interface: data memory port between executor and file memory
`timescale 1ns/1ps
interface bsse_mem_if;
  logic [11:0] addr;
  logic we;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport core (output addr, output we, output wdata, input rdata);
  modport mem (input addr, input we, input wdata, output rdata);
endinterface : bsse_mem_if

// >>> src/bsse_mem.sv
// file memory: 4k x 8 data memory with combinational read
`timescale 1ns/1ps
module bsse_mem (
  input wire logic clk,
  bsse_mem_if.mem port
);
  logic [7:0] ram [0:4095];
  // read is combinational so quarter two sees the value at once
  assign port.rdata = ram[port.addr];
  always_ff @(posedge clk) begin
    if (port.we) begin
      ram[port.addr] <= port.wdata;
    end
  end
endmodule : bsse_mem

// >>> src/bsse_alu.sv
// subtract-with-borrow arithmetic and flags
`timescale 1ns/1ps
module bsse_alu (
  input wire logic [7:0] work,
  input wire logic [7:0] fval,
  input wire logic carry,
  output logic [7:0] result,
  output logic [4:0] flags
);
  logic [8:0] full;
  logic [4:0] low;
  logic neg, ovf, zer, dcy, cy;
  // w - f - !c as w + ~f + c, carry out is the inverted borrow
  assign full = {1'b0, work} + {1'b0, ~fval} + {8'h00, carry};
  assign low = {1'b0, work[3:0]} + {1'b0, ~fval[3:0]} + {4'h0, carry};
  assign result = full[7:0];
  assign cy = full[8];
  assign dcy = low[4];
  assign neg = full[7];
  assign zer = (full[7:0] == 8'h00);
  assign ovf = (work[7] != fval[7]) && (full[7] != work[7]);
  assign flags = {neg, ovf, zer, dcy, cy};
endmodule : bsse_alu

// >>> src/bsse_top.sv
// executor for carry/negative clear branches, sleep and subtract with borrow
// Operation
// - upper byte e3h decodes branch on carry clear, low byte signed offset
// - carry clear: pc gets pc plus 2 plus twice offset, flags kept
// - branches one word; one cycle untaken, two taken with idle second
// - upper byte e7h decodes branch on negative clear with signed offset
// - negative clear: pc plus 2 plus twice offset, else next word
// - fixed code 0003h decodes sleep with no operands
// - sleep sets timeout bit and clears powerdown bit
// - sleep clears watchdog counter to 00h and its postscaler
// - sleep entered in fourth quarter with oscillator stopped
// - watchdog wake from sleep clears the timeout bit
// - subtract computes w minus f minus inverted carry
// - subtract decodes as 01da ffff ffff 0101
// - d zero writes w, d one writes file register
// - a zero uses access bank, a one uses bank select register
// - a zero, extended set, f up to 95 uses indexed literal offset
// - subtract sets negative, overflow, carry, digit carry, zero; one word one cycle
`timescale 1ns/1ps
module bsse_top (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic osc_stop
);
  // ****************************************
  // state
  // ****************************************
  bsse_pkg::bsse_state_e state;
  logic [1:0] quarter;
  logic [15:0] instr;
  logic [15:0] pc;
  logic [7:0] work;
  logic [4:0] status; // neg ovf zero digit carry
  logic [3:0] bank_select_register;
  logic [11:0] fsr2;
  logic ext_set;
  logic timeout_status_bit;
  logic powerdown_status_bit;
  logic [7:0] watchdog_counter;
  logic [7:0] watchdog_postscaler;
  logic [7:0] fval;
  logic [7:0] alu_res;
  logic [4:0] alu_flags;
  bsse_mem_if mif ();
  bsse_mem u_mem (
    .clk(clk),
    .port(mif)
  );
  bsse_alu u_alu (
    .work(work),
    .fval(fval),
    .carry(status[0]),
    .result(alu_res),
    .flags(alu_flags)
  );
  // ****************************************
  // decode
  // ****************************************
  logic is_br_carry, is_br_neg, is_sleep, is_subb, taken, dest_f, acc_a, use_idx;
  logic [15:0] target;
  logic [11:0] ea;
  // opcode match; the codes are disjoint, so at most one is ever true
  assign is_br_carry = (instr[15:8] == bsse_pkg::CARRY_CLEAR_HI);
  assign is_br_neg = (instr[15:8] == bsse_pkg::NEG_CLEAR_HI);
  assign is_sleep = (instr == bsse_pkg::SLEEP_CODE);
  assign is_subb = (instr[15:14] == bsse_pkg::SUBB_TOP) &&
                   (instr[3:0] == bsse_pkg::SUBB_LOW);
  // operand fields of the subtract word
  assign dest_f = instr[13];
  assign acc_a = instr[12];
  // status bits: carry is bit 0, negative is bit 4
  assign taken = (is_br_carry && !status[0]) || (is_br_neg && !status[4]);
  // pc already points at this word; next is pc+2, target adds 2n
  assign target = pc + bsse_pkg::PC_STEP +
                  {{7{instr[7]}}, instr[7:0], 1'b0};
  // indexed mode only for low file addresses with the extended set on
  assign use_idx = !acc_a && ext_set && (instr[11:4] <= bsse_pkg::IDX_LIMIT);
  // access bank low half below 80h, upper half is the sfr page
  assign ea = use_idx ? (fsr2 + {4'h0, instr[11:4]}) :
              acc_a ? {bank_select_register, instr[11:4]} :
              (instr[11] ? {4'hf, instr[11:4]} : {4'h0, instr[11:4]});
  // ****************************************
  // apb slave
  // ****************************************
  logic acc, wr, wtake, busy, idle;
  logic sel_instr, sel_work, sel_status, sel_bank, sel_pc, sel_ctrl;
  logic sel_fsr2, sel_file, sel_faddr, sel_wake, sel_watchdog, sel_busy;
  logic [7:0] rd_mux;
  logic [15:0] pc_read;
  logic [11:0] faddr_reg;
  // bus phases
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  // a write lands only at the edge where pready is sampled high;
  // acting on the first access edge too would double every write
  assign wtake = wr && pready;
  // executor owns the file memory while an instruction runs
  assign busy = (state == bsse_pkg::BSSE_RUN) || (state == bsse_pkg::BSSE_NOP);
  assign idle = (state == bsse_pkg::BSSE_IDLE);
  // register address decode, one select per word
  assign sel_instr = (paddr == bsse_pkg::A_INSTR);
  assign sel_work = (paddr == bsse_pkg::A_WORK);
  assign sel_status = (paddr == bsse_pkg::A_STATUS);
  assign sel_bank = (paddr == bsse_pkg::A_BANK);
  assign sel_pc = (paddr == bsse_pkg::A_PC);
  assign sel_ctrl = (paddr == bsse_pkg::A_CTRL);
  assign sel_fsr2 = (paddr == bsse_pkg::A_FSR2);
  assign sel_file = (paddr == bsse_pkg::A_FILE);
  assign sel_faddr = (paddr == bsse_pkg::A_FADDR);
  assign sel_wake = (paddr == bsse_pkg::A_WAKE);
  assign sel_watchdog = (paddr == bsse_pkg::A_WATCHDOG);
  assign sel_busy = (paddr == bsse_pkg::A_BUSY);
  // memory port: executor address while busy, software pointer otherwise
  assign mif.addr = busy ? ea : faddr_reg;
  // quarter two sees the file value at once, the read is combinational
  assign fval = mif.rdata;
  // software writes reach memory only when idle, so sleep and runs are safe
  assign mif.we = busy ? (state == bsse_pkg::BSSE_RUN && is_subb && dest_f &&
                          quarter == 2'd3)
                       : (idle && wtake && sel_file);
  assign mif.wdata = busy ? alu_res : pwdata[7:0];
  // byte-wide read selection; unmapped words read as zero
  always_comb begin
    if (sel_work) rd_mux = work;
    else if (sel_status) rd_mux = {3'b000, status};
    else if (sel_bank) rd_mux = {4'h0, bank_select_register};
    else if (sel_ctrl)
      rd_mux = {4'h0, osc_stop, powerdown_status_bit, timeout_status_bit, ext_set};
    else if (sel_file) rd_mux = mif.rdata;
    else if (sel_watchdog) rd_mux = watchdog_counter;
    else if (sel_busy) rd_mux = {7'h00, busy};
    else rd_mux = 8'h00;
  end
  // pc is read as a full word
  assign pc_read = pc;
  // one wait state: ready answers at the edge after the first access cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable ? 1'b0 : (acc && !pready);
      pslverr <= 1'b0;
      // capture on reads only, so read data holds across writes
      if (acc && !pready && !pwrite) begin
        if (sel_pc) prdata <= {16'h0000, pc_read};
        else if (sel_fsr2) prdata <= {20'h0_0000, fsr2};
        else if (sel_faddr) prdata <= {20'h0_0000, faddr_reg};
        else prdata <= {24'h00_0000, rd_mux};
      end
    end
  end
  // ****************************************
  // executor: four quarters per instruction cycle
  // ****************************************
  bsse_pkg::bsse_state_e next_state;
  logic last_q, run_end, subb_end, sleep_end, cfg_wr, wake_req;
  // an instruction ends on its fourth quarter
  assign last_q = (quarter == 2'd3);
  assign run_end = (state == bsse_pkg::BSSE_RUN) && last_q;
  assign subb_end = run_end && is_subb;
  assign sleep_end = run_end && is_sleep;
  // software changes registers only while nothing runs; busy writes are dropped
  assign cfg_wr = idle && wtake;
  // in sleep only a wake write is acted on
  assign wake_req = (state == bsse_pkg::BSSE_SLEEP) && wtake && sel_wake && pwdata[0];
  // next state: a taken branch adds one idle instruction cycle
  always_comb begin
    next_state = state;
    case (state)
      bsse_pkg::BSSE_IDLE: begin
        if (cfg_wr && sel_instr) next_state = bsse_pkg::BSSE_RUN;
      end
      bsse_pkg::BSSE_RUN: begin
        if (last_q && taken) next_state = bsse_pkg::BSSE_NOP;
        else if (last_q && is_sleep) next_state = bsse_pkg::BSSE_SLEEP;
        else if (last_q) next_state = bsse_pkg::BSSE_IDLE;
      end
      bsse_pkg::BSSE_NOP: begin
        // second cycle of a taken branch does nothing in any quarter
        if (last_q) next_state = bsse_pkg::BSSE_IDLE;
      end
      bsse_pkg::BSSE_SLEEP: begin
        if (wake_req) next_state = bsse_pkg::BSSE_IDLE;
      end
      default: next_state = bsse_pkg::BSSE_IDLE;
    endcase
  end
  // state register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= bsse_pkg::BSSE_IDLE;
    end else begin
      state <= next_state;
    end
  end
  // quarter counter runs only while busy and wraps after the fourth
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      quarter <= bsse_pkg::Q_RESET;
    end else if (busy) begin
      quarter <= quarter + 2'd1;
    end else begin
      quarter <= bsse_pkg::Q_RESET;
    end
  end
  // instruction word latched as the run starts
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      instr <= 16'h0000;
    end else if (cfg_wr && sel_instr) begin
      instr <= pwdata[15:0];
    end
  end
  // program counter: software load, or advance at the end of an instruction
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pc <= 16'h0000;
    end else if (cfg_wr && sel_pc) begin
      pc <= pwdata[15:0];
    end else if (run_end) begin
      // unknown codes and untaken branches fall through to the next word
      pc <= taken ? target : pc + bsse_pkg::PC_STEP;
    end
  end
  // working register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      work <= 8'h00;
    end else if (cfg_wr && sel_work) begin
      work <= pwdata[7:0];
    end else if (subb_end && !dest_f) begin
      work <= alu_res;
    end
  end
  // status flags; branches and sleep leave them alone
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      status <= 5'h00;
    end else if (cfg_wr && sel_status) begin
      status <= pwdata[4:0];
    end else if (subb_end) begin
      status <= alu_flags;
    end
  end
  // addressing configuration written by software
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bank_select_register <= 4'h0;
      fsr2 <= 12'h000;
      ext_set <= 1'b0;
      faddr_reg <= 12'h000;
    end else if (cfg_wr) begin
      if (sel_bank) bank_select_register <= pwdata[3:0];
      if (sel_ctrl) ext_set <= pwdata[0];
      if (sel_fsr2) fsr2 <= pwdata[11:0];
      if (sel_faddr) faddr_reg <= pwdata[11:0];
    end
  end
  // power status and oscillator stop; sleep entry and wake are
  // in different states, so they can never meet in one cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      timeout_status_bit <= 1'b1;
      powerdown_status_bit <= 1'b1;
      osc_stop <= 1'b0;
    end else if (sleep_end) begin
      timeout_status_bit <= 1'b1;
      powerdown_status_bit <= 1'b0;
      osc_stop <= 1'b1;
    end else if (wake_req) begin
      timeout_status_bit <= 1'b0;
      osc_stop <= 1'b0;
    end
  end
  // watchdog counts clocks only while idle; the postscaler is the low byte,
  // so the counter proper advances once every 256 clocks
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      watchdog_counter <= bsse_pkg::WATCHDOG_CLEAR;
      watchdog_postscaler <= bsse_pkg::WATCHDOG_CLEAR;
    end else if (sleep_end) begin
      watchdog_counter <= bsse_pkg::WATCHDOG_CLEAR;
      watchdog_postscaler <= bsse_pkg::WATCHDOG_CLEAR;
    end else if (idle) begin
      {watchdog_counter, watchdog_postscaler} <=
        {watchdog_counter, watchdog_postscaler} + 16'h0001;
    end
  end
endmodule : bsse_top

// >>> sim/bsse_apb_master.sv
// apb master model that drives the executor's register port
`timescale 1ns/1ps
module bsse_apb_master (
  input wire logic clk,
  input wire logic pready,
  input wire logic [31:0] prdata,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata
);
  // bus idle from time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end
  // ****************************************
  // one transfer, held until pready is sampled
  // ****************************************
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // no cycle count assumed; the bench timeout ends a hang
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : bsse_apb_master

// >>> sim/bsse_properties.sv
// concurrent checks on the executor's register port and sleep output
`timescale 1ns/1ps
module bsse_properties (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic osc_stop
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // ****************************************
  // accepted writes of interest
  // ****************************************
  wire acc = psel && penable && pready && pwrite;
  wire go_sleep = acc && paddr == bsse_pkg::A_INSTR && pwdata[15:0] == bsse_pkg::SLEEP_CODE;
  wire go_wake = acc && paddr == bsse_pkg::A_WAKE && pwdata[0];
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready held over one cycle");
  property p_ready_wait; $rose(psel && penable) |-> !pready; endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("no wait state");
  property p_ready_comes; $rose(psel && penable) |=> pready; endproperty
  a_ready_comes: assert property (p_ready_comes) else $error("pready late");
  property p_ready_phase; pready |-> psel && penable; endproperty
  a_ready_phase: assert property (p_ready_phase) else $error("pready outside access");
  property p_no_err; pready |-> !pslverr; endproperty
  a_no_err: assert property (p_no_err) else $error("slave error raised");
  property p_rdata_hold; $changed(prdata) |-> psel && penable && !pwrite; endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  // stop only in the fourth quarter, never earlier
  property p_sleep_enter; go_sleep |=> !osc_stop [*3] ##[1:6] osc_stop; endproperty
  a_sleep_enter: assert property (p_sleep_enter) else $error("sleep entry timing");
  property p_wake; go_wake && osc_stop |-> ##[1:6] !osc_stop; endproperty
  a_wake: assert property (p_wake) else $error("no wake");
  property p_wake_cause;
    $fell(osc_stop) |-> $past(go_wake) || $past(go_wake, 2) || $past(go_wake, 3);
  endproperty
  a_wake_cause: assert property (p_wake_cause) else $error("wake without request");
  c_sleep: cover property (go_sleep);
  c_wake: cover property (go_wake && osc_stop);
  c_read: cover property (pready && !pwrite);
endmodule : bsse_properties

bind bsse_top bsse_properties u_props (.clk, .reset, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .osc_stop);

// >>> sim/branch_sleep_subtract_exec_bench.sv
// self-checking bench for the branch, sleep and subtract executor
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin errors++; \
  $display("BAD %0t got %h want %h", $time, (g), (e)); end end
module branch_sleep_subtract_exec_bench;
  typedef struct packed {
    logic [15:0] op, pc, epc;
    logic [7:0] w, st, f, ew, est, ef;
  } bsse_row_s;
  logic clk, reset, psel, penable, pwrite, pready, pslverr, osc_stop;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  int errors, n_compared;
  int cyc = 0;
  // ****************************************
  // op, pc, pc after, w, status, file, then expected w, status, file
  // ****************************************
  bsse_row_s rows [9] = '{
    '{16'he305, 16'h0100, 16'h010c, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00},
    '{16'he305, 16'h0100, 16'h0102, 8'h00, 8'h01, 8'h00, 8'h00, 8'h01, 8'h00},
    '{16'he380, 16'h0200, 16'h0102, 8'h00, 8'h10, 8'h00, 8'h00, 8'h10, 8'h00},
    '{16'he77f, 16'h0100, 16'h0200, 8'h00, 8'h01, 8'h00, 8'h00, 8'h01, 8'h00},
    '{16'he77f, 16'h0100, 16'h0102, 8'h00, 8'h10, 8'h00, 8'h00, 8'h10, 8'h00},
    '{16'h7405, 16'h0000, 16'h0002, 8'h02, 8'h01, 8'h03, 8'h02, 8'h10, 8'hff},
    '{16'h5405, 16'h0000, 16'h0002, 8'h05, 8'h01, 8'h02, 8'h03, 8'h03, 8'h02},
    '{16'h7405, 16'h0000, 16'h0002, 8'h02, 8'h00, 8'h01, 8'h02, 8'h07, 8'h00},
    '{16'h5405, 16'h0000, 16'h0002, 8'h80, 8'h01, 8'h01, 8'h7f, 8'h09, 8'h01}};
  // free-running 40 mhz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  bsse_top dut (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .osc_stop);
  bsse_apb_master m (.clk, .pready, .prdata, .psel, .penable, .pwrite, .paddr, .pwdata);
  // hang guard, far above the few hundred cycles needed
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      summarize();
    end
  end
  task automatic summarize();
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    m.xfer(1'b1, a, d, r);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    m.xfer(1'b0, a, 32'h0000_0000, r);
  endtask : rd
  // start an instruction and poll busy until it drops
  task automatic exec(input logic [15:0] op);
    logic [31:0] r;
    wr(bsse_pkg::A_INSTR, 32'(op));
    r = 32'h0000_0001;
    for (int i = 0; i < 40 && r[0] !== 1'b0; i++) rd(bsse_pkg::A_BUSY, r);
  endtask : exec
  initial begin
    errors = 0;
    n_compared = 0;
    reset = 1'b1;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    rd(bsse_pkg::A_CTRL, q);
    `CHK(q, 32'h0000_0006)
    wr(bsse_pkg::A_BANK, 32'h0000_0001);
    wr(bsse_pkg::A_FADDR, 32'h0000_0140);
    foreach (rows[i]) begin
      wr(bsse_pkg::A_FILE, 32'(rows[i].f));
      wr(bsse_pkg::A_WORK, 32'(rows[i].w));
      wr(bsse_pkg::A_STATUS, 32'(rows[i].st));
      wr(bsse_pkg::A_PC, 32'(rows[i].pc));
      exec(rows[i].op);
      rd(bsse_pkg::A_WORK, q);
      `CHK(q[7:0], rows[i].ew)
      rd(bsse_pkg::A_STATUS, q);
      `CHK(q[4:0], rows[i].est[4:0])
      rd(bsse_pkg::A_PC, q);
      `CHK(q[15:0], rows[i].epc)
      rd(bsse_pkg::A_FILE, q);
      `CHK(q[7:0], rows[i].ef)
    end
    // access bank versus indexed offset, same opcode
    for (int e = 0; e < 2; e++) begin
      wr(bsse_pkg::A_CTRL, 32'(e));
      wr(bsse_pkg::A_FSR2, 32'h0000_0100);
      wr(bsse_pkg::A_FADDR, 32'h0000_0110);
      wr(bsse_pkg::A_FILE, 32'h0000_0003);
      wr(bsse_pkg::A_FADDR, 32'h0000_0010);
      wr(bsse_pkg::A_FILE, 32'h0000_0003);
      wr(bsse_pkg::A_WORK, 32'h0000_0002);
      wr(bsse_pkg::A_STATUS, 32'h0000_0001);
      exec(16'h6105);
      wr(bsse_pkg::A_FADDR, e ? 32'h0000_0110 : 32'h0000_0010);
      rd(bsse_pkg::A_FILE, q);
      `CHK(q[7:0], 8'hff)
    end
    rd(8'h30, q);
    `CHK(q, 32'h0000_0000)
    // sleep, then watchdog wake
    wr(bsse_pkg::A_INSTR, 32'(bsse_pkg::SLEEP_CODE));
    for (int i = 0; i < 20 && osc_stop !== 1'b1; i++) @(posedge clk);
    `CHK(osc_stop, 1'b1)
    rd(bsse_pkg::A_CTRL, q);
    `CHK(q[3:1], 3'b101)
    rd(bsse_pkg::A_WATCHDOG, q);
    `CHK(q, 32'(bsse_pkg::WATCHDOG_CLEAR))
    wr(bsse_pkg::A_WAKE, 32'h0000_0001);
    for (int i = 0; i < 20 && osc_stop !== 1'b0; i++) @(posedge clk);
    rd(bsse_pkg::A_CTRL, q);
    `CHK(q[3:1], 3'b000)
    summarize();
  end
endmodule : branch_sleep_subtract_exec_bench
